// ---- hw/reset_seq_pkg.sv ----
// Constants, register map and state type of the system reset sequencer
package reset_seq_pkg;

  // ****************************************
  // Timing base
  // ****************************************
  localparam int CLK_NS = 50;
  localparam int TCL_NS = CLK_NS / 2;
  localparam int SPIKE_NS = 50;
  localparam int FILTER_NS = 250;
  localparam int MIN_LOW_TCL = 4;
  localparam int PREP_TCL = 12;
  localparam int SEQ_TCL = 1024;
  localparam int TAIL_TCL = 8;
  localparam int EXIT_TCL = 4;
  localparam int FLASH_INIT_NS = 1000000;

  // Least times round up to whole clocks
  function automatic int tcl_cycles(input int half_period_unit);
    return (half_period_unit * TCL_NS + CLK_NS - 1) / CLK_NS;
  endfunction : tcl_cycles

  localparam logic [2:0] FILTER_LAST = 3'((FILTER_NS + CLK_NS - 1) / CLK_NS - 1);
  localparam logic [15:0] PREP_LAST = 16'(tcl_cycles(PREP_TCL) - 1);
  localparam logic [15:0] SEQ_LAST = 16'(tcl_cycles(SEQ_TCL) - 1);
  localparam logic [15:0] TAIL_LAST = 16'(tcl_cycles(TAIL_TCL) - 1);
  localparam logic [15:0] EXIT_LAST = 16'(tcl_cycles(EXIT_TCL) - 1);
  localparam int FLASH_INIT_CYC = FLASH_INIT_NS / CLK_NS;
  localparam logic [15:0] FLASH_BLANK_CYC = 16'h0010;

  // ****************************************
  // Data values
  // ****************************************
  localparam logic [15:0] FLASH_BLANK_DATA = 16'hFFFF;
  localparam logic [15:0] FLASH_TRAP_DATA = 16'h009B;
  localparam logic [23:0] RESET_VECTOR = 24'h000000;

  // ****************************************
  // Register map
  // ****************************************
  localparam int ADDR_W = 4;
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] STATUS_ADDR = 4'h4;
  localparam logic [3:0] CONFIG_ADDR = 4'h8;
  localparam int END_INIT_INSTRUCTION_BIT = 0;
  localparam int BIDIR_BIT = 3;
  localparam int SHORT_BIT = 0;
  localparam int LONG_BIT = 1;
  localparam int ASYNC_BIT = 2;
  localparam int END_INIT_INSTRUCTION_DONE_BIT = 3;
  localparam int INT_RST_BIT = 4;
  localparam int FLASH_DONE_BIT = 5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_RUN, ST_PREP, ST_SEQ, ST_TAIL, ST_LONG, ST_ASYNC, ST_EXIT
  } seq_state_t;

endpackage : reset_seq_pkg

// ---- hw/system_reset_sequencer.sv ----
// System reset sequencer with filtered reset input and AXI4-Lite registers
//
// Implementation choices: the register addresses and the AXI4-Lite slave port.

// Summary of operation
// R01 - Reset input lows shorter than 50 ns are ignored; filter settles within 500 ns.
// R02 - Outside circuitry holds reset input low over 500 ns to be seen.
// R03 - Mode-sense low stops software or watchdog resets from pulling the reset pin.
// R04 - Reset input low with mode-sense low forces reset state at once.
// R05 - Asynchronous reset: reset output low, holds cancelled, buses float, config pulled high.
// R06 - Applications should prefer synchronous reset to protect internal memory content.
// R07 - Asynchronous detection needs no running clock.
// R08 - At power-on outside holds reset and mode-sense low until clock and config settle.
// R09 - Power-on low time covers oscillator start-up and PLL lock.
// R10 - Internal boot keeps internal reset until flash initialization ends, at most 1 ms.
// R11 - External boot releases internal reset filter delay plus 3 to 8 units later.
// R12 - Flash reads before initialization return FFFFh first, then 009Bh.
// R13 - Reset input low plus mode-sense low, now or later, gives asynchronous reset.
// R14 - On exit latch config port, strobes inactive, start at address zero.
// R15 - Reset input low with mode-sense high starts a synchronous reset.
// R16 - Sync reset floats I/O, drives reset output low, cancels holds within 12 units.
// R17 - Reset pin pull-down only if bidirectional enable set; enable cleared after sequences.
// R18 - After 12 units run 1024 units, wait 8, then classify short or long.
// R19 - Long reset makes config port bits 15 to 13 transparent.
// R20 - Outside never powers the device without reset input held low.
// R21 - Bidirectional short reset holds reset pin low until the 1024-unit sequence ends.
// R22 - Bidirectional enable is control bit 3, writable only before end of init.
// R23 - Reset input and mode-sense are synchronized before the sequence logic uses them.
module system_reset_sequencer #(
  parameter int FLASH_INIT_CYC = reset_seq_pkg::FLASH_INIT_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Reset pins
  input wire logic reset_in_n,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  input wire logic reset_mode_sense,
  output logic reset_out_n,
  // System side
  input wire logic external_boot_select_n,
  input wire logic soft_reset_req,
  input wire logic [15:0] config_port,
  output logic [15:0] config_latched,
  output logic config_transparent,
  output logic config_pullup,
  output logic bus_float,
  output logic hold_cancel,
  output logic bus_abort,
  output logic internal_reset_n,
  output logic [23:0] start_vector,
  // CPU strobes
  input wire logic cpu_ale,
  input wire logic cpu_rd_n,
  input wire logic cpu_wr_n,
  output logic addr_latch_en,
  output logic read_strobe_n,
  output logic write_strobe_n,
  // Flash
  input wire logic flash_ready,
  input wire logic flash_rd_req,
  input wire logic [15:0] flash_rdata_in,
  output logic [15:0] flash_rdata
);

  // ****************************************
  // Input conditioning
  // ****************************************
  logic rin_meta_reg, rin_sync_reg, mode_meta_reg, mode_sync_reg;
  logic filt_reg;
  logic [2:0] filt_cnt_reg;
  logic async_rst;

  // No clock needed: raw pins act straight on the reset flops
  assign async_rst = !reset_in_n && !reset_mode_sense; // R07

  always_ff @(posedge aclk) begin
    rin_meta_reg <= reset_in_n; // R23
    rin_sync_reg <= rin_meta_reg;
    mode_meta_reg <= reset_mode_sense;
    mode_sync_reg <= mode_meta_reg;
  end

  // Level must stand a full filter window before it is believed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filt_reg <= 1'b0;
      filt_cnt_reg <= 3'h0;
    end else if (rin_sync_reg == filt_reg) begin
      filt_cnt_reg <= 3'h0;
    end else if (filt_cnt_reg == reset_seq_pkg::FILTER_LAST) begin
      filt_reg <= rin_sync_reg; // R01
      filt_cnt_reg <= 3'h0;
    end else begin
      filt_cnt_reg <= filt_cnt_reg + 3'h1;
    end
  end

  // ****************************************
  // Sequence state
  // ****************************************
  reset_seq_pkg::seq_state_t state_reg, state_next;
  logic [15:0] cnt_reg;
  logic hw_reg, pin_allow_reg, bidir_reg, end_init_instruction_reg, flash_done_reg;
  logic [15:0] flash_cnt_reg;
  logic hw_start, start_now, allow_now, exit_ok;

  assign hw_start = !filt_reg && mode_sync_reg; // R15
  assign start_now = hw_start || soft_reset_req;
  assign allow_now = bidir_reg && (hw_start || mode_sync_reg); // R03
  assign exit_ok = external_boot_select_n ? flash_done_reg // R10
                 : (cnt_reg == reset_seq_pkg::EXIT_LAST); // R11

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      reset_seq_pkg::ST_RUN: begin
        if (start_now) state_next = reset_seq_pkg::ST_PREP;
      end
      reset_seq_pkg::ST_PREP: begin
        if (cnt_reg == reset_seq_pkg::PREP_LAST) state_next = reset_seq_pkg::ST_SEQ; // R16
      end
      reset_seq_pkg::ST_SEQ: begin
        if (cnt_reg == reset_seq_pkg::SEQ_LAST) state_next = reset_seq_pkg::ST_TAIL; // R18
      end
      reset_seq_pkg::ST_TAIL: begin
        if (cnt_reg == reset_seq_pkg::TAIL_LAST) begin
          state_next = (hw_reg && !filt_reg) ? reset_seq_pkg::ST_LONG // R18
                     : reset_seq_pkg::ST_EXIT;
        end
      end
      reset_seq_pkg::ST_LONG, reset_seq_pkg::ST_ASYNC: begin
        if (filt_reg) state_next = reset_seq_pkg::ST_EXIT;
      end
      reset_seq_pkg::ST_EXIT: begin
        if (exit_ok) state_next = reset_seq_pkg::ST_RUN;
      end
      default: state_next = reset_seq_pkg::ST_ASYNC;
    endcase
  end

  // Async path only loads constants; release is clocked
  always_ff @(posedge aclk or posedge async_rst) begin
    if (async_rst) begin
      state_reg <= reset_seq_pkg::ST_ASYNC; // R04 R13
      cnt_reg <= 16'h0000;
    end else if (!aresetn) begin
      state_reg <= reset_seq_pkg::ST_ASYNC;
      cnt_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      cnt_reg <= (state_next != state_reg) ? 16'h0000 : cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hw_reg <= 1'b0;
      pin_allow_reg <= 1'b0;
    end else if (state_reg == reset_seq_pkg::ST_RUN && start_now) begin
      hw_reg <= hw_start;
      pin_allow_reg <= allow_now;
    end
  end

  // ****************************************
  // Pin and system outputs
  // ****************************************
  always_ff @(posedge aclk or posedge async_rst) begin
    if (async_rst) begin
      reset_out_n <= 1'b0; // R05
      bus_float <= 1'b1;
      config_pullup <= 1'b1;
      hold_cancel <= 1'b1;
      bus_abort <= 1'b1;
      internal_reset_n <= 1'b0;
      config_transparent <= 1'b0;
      reset_pin_oe <= 1'b0;
      reset_pin_out <= 1'b0;
    end else if (!aresetn) begin
      reset_out_n <= 1'b0;
      bus_float <= 1'b1;
      config_pullup <= 1'b1;
      hold_cancel <= 1'b1;
      bus_abort <= 1'b1;
      internal_reset_n <= 1'b0;
      config_transparent <= 1'b0;
      reset_pin_oe <= 1'b0;
      reset_pin_out <= 1'b0;
    end else begin
      reset_out_n <= state_reg == reset_seq_pkg::ST_RUN && !start_now && end_init_instruction_reg; // R16
      bus_float <= state_next != reset_seq_pkg::ST_RUN; // R16
      config_pullup <= state_next == reset_seq_pkg::ST_ASYNC;
      hold_cancel <= state_next == reset_seq_pkg::ST_PREP || state_next == reset_seq_pkg::ST_ASYNC;
      bus_abort <= state_next == reset_seq_pkg::ST_PREP || state_next == reset_seq_pkg::ST_ASYNC;
      internal_reset_n <= state_next == reset_seq_pkg::ST_RUN; // R10 R11
      config_transparent <= state_next == reset_seq_pkg::ST_LONG; // R19
      reset_pin_oe <= ((state_reg == reset_seq_pkg::ST_RUN) ? allow_now : pin_allow_reg)
        && (state_next == reset_seq_pkg::ST_PREP || state_next == reset_seq_pkg::ST_SEQ); // R17 R21
      reset_pin_out <= 1'b0;
    end
  end

  // Strobes forced inactive whenever the CPU is held
  always_ff @(posedge aclk) begin
    if (!aresetn || state_next != reset_seq_pkg::ST_RUN) begin
      addr_latch_en <= 1'b0; // R14
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
    end else begin
      addr_latch_en <= cpu_ale;
      read_strobe_n <= cpu_rd_n;
      write_strobe_n <= cpu_wr_n;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_latched <= 16'hFFFF;
      start_vector <= reset_seq_pkg::RESET_VECTOR;
    end else if (state_reg == reset_seq_pkg::ST_EXIT && exit_ok) begin
      config_latched <= config_port; // R14
      start_vector <= reset_seq_pkg::RESET_VECTOR;
    end else if (state_reg == reset_seq_pkg::ST_LONG) begin
      config_latched[15:13] <= config_port[15:13]; // R19
    end
  end

  // ****************************************
  // Flash initialization tracking
  // ****************************************
  logic in_reset;
  assign in_reset = state_reg != reset_seq_pkg::ST_RUN && state_reg != reset_seq_pkg::ST_EXIT;

  // Timeout bounds the wait should the flash never report ready
  always_ff @(posedge aclk) begin
    if (!aresetn || in_reset) begin
      flash_cnt_reg <= 16'h0000;
      flash_done_reg <= 1'b0;
    end else if (!flash_done_reg) begin
      flash_cnt_reg <= flash_cnt_reg + 16'h0001;
      flash_done_reg <= flash_ready || flash_cnt_reg == 16'(FLASH_INIT_CYC - 1); // R10
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_rdata <= reset_seq_pkg::FLASH_BLANK_DATA;
    end else if (flash_rd_req) begin
      if (flash_done_reg) flash_rdata <= flash_rdata_in;
      else if (flash_cnt_reg < reset_seq_pkg::FLASH_BLANK_CYC) // R12
        flash_rdata <= reset_seq_pkg::FLASH_BLANK_DATA;
      else flash_rdata <= reset_seq_pkg::FLASH_TRAP_DATA;
    end
  end

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  logic [3:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire, ctrl_wr;
  logic short_flag_reg, long_flag_reg, async_flag_reg;
  logic [31:0] rd_value;
  logic rd_hit;

  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign ctrl_wr = wr_fire && awaddr_q == reset_seq_pkg::CTRL_ADDR && wstrb_q[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= reset_seq_pkg::RESP_OKAY;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q == reset_seq_pkg::CTRL_ADDR) ? reset_seq_pkg::RESP_OKAY
                     : reset_seq_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_value = 32'h00000000;
    rd_hit = 1'b1;
    if (s_axi_araddr == reset_seq_pkg::CTRL_ADDR) begin
      rd_value[reset_seq_pkg::BIDIR_BIT] = bidir_reg;
      rd_value[reset_seq_pkg::END_INIT_INSTRUCTION_BIT] = end_init_instruction_reg;
    end else if (s_axi_araddr == reset_seq_pkg::STATUS_ADDR) begin
      rd_value[reset_seq_pkg::SHORT_BIT] = short_flag_reg;
      rd_value[reset_seq_pkg::LONG_BIT] = long_flag_reg;
      rd_value[reset_seq_pkg::ASYNC_BIT] = async_flag_reg;
      rd_value[reset_seq_pkg::END_INIT_INSTRUCTION_DONE_BIT] = end_init_instruction_reg;
      rd_value[reset_seq_pkg::INT_RST_BIT] = internal_reset_n;
      rd_value[reset_seq_pkg::FLASH_DONE_BIT] = flash_done_reg;
    end else if (s_axi_araddr == reset_seq_pkg::CONFIG_ADDR) begin
      rd_value[15:0] = config_latched;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= reset_seq_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_value;
      s_axi_rresp <= rd_hit ? reset_seq_pkg::RESP_OKAY : reset_seq_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************
  // Control bits and reset flags
  // ****************************************
  // Bidirectional enable is writable only until end of init and clears in ST_ASYNC or ST_EXIT
  always_ff @(posedge aclk) begin
    if (!aresetn || state_reg == reset_seq_pkg::ST_ASYNC || state_reg == reset_seq_pkg::ST_EXIT) begin
      bidir_reg <= 1'b0; // R17
    end else if (ctrl_wr && !end_init_instruction_reg) begin
      bidir_reg <= wdata_q[reset_seq_pkg::BIDIR_BIT]; // R22
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || state_reg != reset_seq_pkg::ST_RUN) end_init_instruction_reg <= 1'b0;
    else if (ctrl_wr && wdata_q[reset_seq_pkg::END_INIT_INSTRUCTION_BIT]) end_init_instruction_reg <= 1'b1;
  end

  // Hardware set outranks the end-of-init clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      short_flag_reg <= 1'b0;
      long_flag_reg <= 1'b0;
      async_flag_reg <= 1'b0;
    end else begin
      if (state_reg == reset_seq_pkg::ST_TAIL && state_next != state_reg && hw_reg)
        short_flag_reg <= 1'b1; // R18
      else if (ctrl_wr && wdata_q[reset_seq_pkg::END_INIT_INSTRUCTION_BIT]) short_flag_reg <= 1'b0;
      if (state_next == reset_seq_pkg::ST_LONG) long_flag_reg <= 1'b1; // R18
      else if (ctrl_wr && wdata_q[reset_seq_pkg::END_INIT_INSTRUCTION_BIT]) long_flag_reg <= 1'b0;
      if (state_reg == reset_seq_pkg::ST_ASYNC) async_flag_reg <= 1'b1;
      else if (ctrl_wr && wdata_q[reset_seq_pkg::END_INIT_INSTRUCTION_BIT]) async_flag_reg <= 1'b0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  AST_SYNC_START: assert property (@(posedge aclk) disable iff (!aresetn || async_rst) // R15
    state_reg == reset_seq_pkg::ST_RUN && hw_start |=> state_reg == reset_seq_pkg::ST_PREP
      && !reset_out_n && bus_float)
    else $error("sync reset not started");
  AST_PREP_LEN: assert property (@(posedge aclk) disable iff (!aresetn || async_rst) // R16
    $rose(state_reg == reset_seq_pkg::ST_PREP) |-> hold_cancel[*6] ##1
      state_reg == reset_seq_pkg::ST_SEQ)
    else $error("prep phase length wrong");
  AST_SEQ_BOUND: assert property (@(posedge aclk) disable iff (!aresetn || async_rst) // R18
    state_reg == reset_seq_pkg::ST_SEQ |-> cnt_reg <= reset_seq_pkg::SEQ_LAST)
    else $error("internal sequence overran");
  AST_LONG_CLASS: assert property (@(posedge aclk) disable iff (!aresetn || async_rst) // R18
    state_reg == reset_seq_pkg::ST_TAIL && cnt_reg == reset_seq_pkg::TAIL_LAST && hw_reg
      && !filt_reg |=> state_reg == reset_seq_pkg::ST_LONG ##1 long_flag_reg && short_flag_reg)
    else $error("long reset not flagged");
  AST_ASYNC_OUT: assert property (@(posedge aclk) disable iff (!aresetn) // R05
    state_reg == reset_seq_pkg::ST_ASYNC && $past(state_reg) == reset_seq_pkg::ST_ASYNC
      |-> !reset_out_n && bus_float && config_pullup && !internal_reset_n)
    else $error("async reset outputs wrong");
  AST_PIN_GATE: assert property (@(posedge aclk) disable iff (!aresetn || async_rst) // R03 R17
    reset_pin_oe |-> pin_allow_reg && !reset_pin_out)
    else $error("reset pin driven without enable");
  AST_PIN_RELEASE: assert property (@(posedge aclk) disable iff (!aresetn || async_rst) // R21
    reset_pin_oe && state_reg == reset_seq_pkg::ST_SEQ && cnt_reg == reset_seq_pkg::SEQ_LAST
      |=> !reset_pin_oe)
    else $error("reset pin held past sequence");
  AST_FLASH_GATE: assert property (@(posedge aclk) disable iff (!aresetn || async_rst) // R10
    $rose(internal_reset_n) && external_boot_select_n |-> flash_done_reg)
    else $error("internal reset released before flash ready");
  AST_TRANSP: assert property (@(posedge aclk) disable iff (!aresetn || async_rst) // R19
    config_transparent |-> state_reg == reset_seq_pkg::ST_LONG)
    else $error("config transparent outside long reset");
  AST_FLASH_DATA: assert property (@(posedge aclk) disable iff (!aresetn) // R12
    flash_rd_req && !flash_done_reg && flash_cnt_reg >= reset_seq_pkg::FLASH_BLANK_CYC
      |=> flash_rdata == reset_seq_pkg::FLASH_TRAP_DATA)
    else $error("early flash read value wrong");

endmodule : system_reset_sequencer

// ---- tb/reset_partner.sv ----
// Outside reset circuitry: supervisor, reset button and mode-sense capacitor
module reset_partner (
  // Clock
  input wire logic aclk,
  // Reset pin and mode sense
  output logic reset_in_n,
  output logic reset_mode_sense,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drive_low = 1'b1;
  initial reset_mode_sense = 1'b0;
  // Open-drain pin with pull-up: low while either side pulls
  assign reset_in_n = !(drive_low || (reset_pin_oe && !reset_pin_out));
  task automatic power_on(input int cycles);
    repeat (cycles) @(posedge aclk);
    drive_low <= 1'b0;
    repeat (2) @(posedge aclk);
    reset_mode_sense <= 1'b1;
  endtask : power_on
  // Presses start mid-cycle, as a button would
  task automatic hold_low(input logic mode, input int cycles);
    @(posedge aclk);
    #10;
    reset_mode_sense = mode;
    drive_low = 1'b1;
    repeat (cycles) @(posedge aclk);
    drive_low <= 1'b0;
    repeat (2) @(posedge aclk);
    reset_mode_sense <= 1'b1;
  endtask : hold_low
  task automatic spike(input int ns);
    @(posedge aclk);
    #10;
    drive_low = 1'b1;
    #(ns);
    drive_low = 1'b0;
  endtask : spike
endmodule : reset_partner

// ---- tb/system_reset_sequencer_test.sv ----
// Self-checking bench of the system reset sequencer
module system_reset_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FLASH_CYC = 50;
  localparam logic [3:0] CTRL = reset_seq_pkg::CTRL_ADDR;
  localparam logic [3:0] STAT = reset_seq_pkg::STATUS_ADDR;
  localparam logic [1:0] OK = reset_seq_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = reset_seq_pkg::RESP_SLVERR;
  typedef struct packed {
    logic [31:0] data;
    logic [31:0] mask;
    logic [1:0] resp;
  } note_t;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic reset_in_n, reset_pin_out, reset_pin_oe, reset_mode_sense, reset_out_n;
  logic external_boot_select_n = 1'b0, soft_reset_req = 1'b0, flash_ready = 1'b1;
  logic config_transparent, config_pullup, bus_float, hold_cancel, bus_abort;
  logic internal_reset_n, addr_latch_en, read_strobe_n, write_strobe_n;
  logic cpu_ale = 1'b0, cpu_rd_n = 1'b1, cpu_wr_n = 1'b0, flash_rd_req = 1'b0;
  logic [15:0] config_port, config_latched, flash_rdata_in = 16'h1234, flash_rdata;
  logic [23:0] start_vector;
  note_t notes[$];
  note_t note;
  int n_mismatch = 0, tests_run = 0, cycles = 0, took = 0, seed = 36;
  logic [15:0] cfg;

`define CHECK(what, exp, got) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("MISMATCH %s expected %h seen %h", what, exp, got); \
  end \
end

  always #25 aclk = ~aclk;

  system_reset_sequencer #(.FLASH_INIT_CYC(FLASH_CYC)) i_system_reset_sequencer (.*);
  reset_partner i_reset_partner (.aclk, .reset_in_n, .reset_mode_sense, .reset_pin_out,
    .reset_pin_oe);

  // ****************************************
  // Bus driver, result watcher, closing
  // ****************************************
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 4000) begin
      n_mismatch++;
      test_done();
    end
    if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
      note = (notes.size() > 0) ? notes.pop_front() : '1;
      if (s_axi_bvalid) begin
        `CHECK("bresp", note.resp, s_axi_bresp)
      end else begin
        `CHECK("rresp", note.resp, s_axi_rresp)
        `CHECK("rdata", note.data, s_axi_rdata & note.mask)
      end
    end
  end

  task automatic axi_write(input logic [3:0] addr, input logic [31:0] data,
                           input logic [1:0] resp);
    notes.push_back('{32'h0, 32'h0, resp});
    @(posedge aclk);
    s_axi_awaddr <= addr;
    s_axi_wdata <= data;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (!s_axi_wready);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [3:0] addr, input logic [31:0] data,
                          input logic [31:0] mask, input logic [1:0] resp);
    notes.push_back('{data, mask, resp});
    @(posedge aclk);
    s_axi_araddr <= addr;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : axi_read

  task automatic wait_level(ref logic sig, input logic lvl, input int max);
    took = 0;
    while (sig !== lvl && took < max) begin
      @(posedge aclk);
      #1;
      took++;
    end
    `CHECK("level", lvl, sig)
  endtask : wait_level

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    cfg = 16'($random(seed));
    config_port = cfg;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    `CHECK("pullup", 1'b1, config_pullup & bus_float & !reset_out_n)
    i_reset_partner.power_on(17);
    wait_level(internal_reset_n, 1'b1, 16);
    `CHECK("exit_time", 1'b1, took <= 12)
    `CHECK("vector", 24'h000000, start_vector)
    `CHECK("latched", cfg, config_latched)
    `CHECK("wr_strobe", cpu_wr_n, write_strobe_n)
    axi_write(CTRL, 32'h8, OK);
    axi_read(CTRL, 32'h8, 32'h9, OK);
    fork
      i_reset_partner.hold_low(1'b1, 12);
      begin
        wait_level(bus_float, 1'b1, 12);
        `CHECK("out_n", 1'b0, reset_out_n)
        `CHECK("cancel", 1'b1, hold_cancel & bus_abort)
        `CHECK("pin_oe", 1'b1, reset_pin_oe)
        `CHECK("wr_idle", 1'b1, write_strobe_n)
        repeat (300) @(posedge aclk);
        `CHECK("pin_held", 1'b0, reset_in_n)
      end
    join
    wait_level(internal_reset_n, 1'b1, 300);
    axi_read(CTRL, 32'h0, 32'h8, OK);
    axi_read(STAT, 32'h14, 32'h14, OK);
    axi_write(CTRL, 32'h1, OK);
    wait_level(reset_out_n, 1'b1, 4);
    axi_write(CTRL, 32'h9, OK);
    axi_read(CTRL, 32'h1, 32'h9, OK);
    axi_read(STAT, 32'h18, 32'h1F, OK);
    axi_write(STAT, 32'h3, ERR);
    axi_read(4'hC, 32'h0, 32'hFFFFFFFF, ERR);
    i_reset_partner.spike(30);
    repeat (15) @(posedge aclk);
    `CHECK("spike", 1'b1, internal_reset_n)
    fork
      i_reset_partner.hold_low(1'b1, 20);
      begin
        repeat (500) @(posedge aclk);
        `CHECK("in_seq", 1'b0, internal_reset_n)
      end
    join
    wait_level(internal_reset_n, 1'b1, 60);
    axi_read(STAT, 32'h1, 32'h3, OK);
    external_boot_select_n <= 1'b1;
    flash_ready <= 1'b0;
    fork
      i_reset_partner.hold_low(1'b1, 560);
      begin
        repeat (545) @(posedge aclk);
        cfg = 16'($random(seed));
        config_port <= cfg;
        repeat (3) @(posedge aclk);
        #1;
        `CHECK("transparent", 1'b1, config_transparent)
        `CHECK("top_bits", cfg[15:13], config_latched[15:13])
      end
    join
    fork
      wait_level(internal_reset_n, 1'b1, 90);
      begin
        repeat (40) @(posedge aclk);
        flash_rd_req <= 1'b1;
        @(posedge aclk);
        flash_rd_req <= 1'b0;
        #1;
        `CHECK("early_flash", reset_seq_pkg::FLASH_TRAP_DATA, flash_rdata)
      end
    join
    `CHECK("flash_wait", 1'b1, took >= 45)
    flash_ready <= 1'b1;
    axi_read(STAT, 32'h3, 32'h3, OK);
    axi_write(CTRL, 32'h1, OK);
    fork
      i_reset_partner.hold_low(1'b0, 10);
      begin
        @(posedge aclk);
        #20;
        `CHECK("async_now", 1'b0, internal_reset_n)
        `CHECK("async_pull", 1'b1, config_pullup)
      end
    join
    wait_level(internal_reset_n, 1'b1, 40);
    `CHECK("latched2", cfg, config_latched)
    axi_read(STAT, 32'h4, 32'h7, OK);
    soft_reset_req <= 1'b1;
    @(posedge aclk);
    soft_reset_req <= 1'b0;
    wait_level(internal_reset_n, 1'b0, 2);
    wait_level(internal_reset_n, 1'b1, 600);
    test_done();
  end
endmodule : system_reset_sequencer_test
